// *** rtl/adas_pkg.sv ***
// constants and types for the aperture delay adjust and calibration status block
// Notes on behaviour
// RQ1: done flag reads 1 only while timing calibration is enabled and has finished.
// RQ2: status field returns the 17-bit calibrated delay word, valid only when done.
// RQ3: delay word bit 16 is inversion, bits 15:8 coarse, bits 7:0 fine.
// RQ4: manual inversion bit set inverts the sampling clock.
// RQ5: with calibration disabled, manual coarse field drives the applied coarse delay.
// RQ6: with calibration disabled, manual fine field drives the applied fine delay.
// RQ7: fine delay accepts any new value at any time, applied without deferral.
// RQ8: host keeps inversion bit fixed while converter calibration or link is enabled.
// RQ9: host moves coarse by at most four codes per update while those run.
// RQ10: host should step coarse one code per write while those run.
// RQ11: host meets coarse limit by small writes or by the coarse ramp.
// RQ12: rising calibration enable starts calibration; manual register ignored while enabled.
// RQ13: with ramp on, applied coarse moves one code per 384 cycles at slow rate.
// RQ14: done reads 0 while enable is low and clears when a new sequence starts.
package adas_pkg;
	// serial port frame: read flag, 15-bit address, 8-bit data
	localparam int ADDR_W = 15;
	localparam int BYTE_W = 8;
	localparam logic [4:0] HEADER_BITS = 5'h10;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam int SYNC_STAGES = 3;

	// register byte addresses, low byte at the printed offset
	localparam logic [14:0] STATUS_OFS = 15'h02b2;
	localparam logic [14:0] MANUAL_OFS = 15'h02b5;

	// field layout of the delay word and the status register
	localparam int WORD_W = 17;
	localparam int INV_POS = 16;
	localparam int COARSE_LSB = 8;
	localparam int FINE_LSB = 0;
	localparam int DONE_POS = 17;

	// reset values
	localparam logic [16:0] WORD_RESET = 17'h00000;
	localparam logic [7:0] FIELD_RESET = 8'h00;
	localparam logic DONE_RESET = 1'b0;

	// coarse ramp timing
	localparam int RAMP_INTERVAL_CYC = 384;
	localparam logic [7:0] RAMP_SLOW_STEP = 8'h01;
	localparam logic [7:0] RAMP_FAST_STEP = 8'h04;

	typedef enum logic [1:0] {PH_IDLE, PH_HEAD, PH_DATA, PH_WAIT} adas_phase_type;
endpackage

// *** rtl/adas_coarse_ramp.sv ***
// coarse delay ramp that walks the applied coarse code toward its target
`timescale 1ns/100ps
module adas_coarse_ramp #(
	parameter int INTERVAL = adas_pkg::RAMP_INTERVAL_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] target,
	input wire logic ramp_enable,
	input wire logic fast_rate,
	output logic [7:0] applied
);
	localparam logic [8:0] CNT_LAST = 9'(INTERVAL - 1);

	logic [8:0] tick_cnt;
	logic [8:0] next_tick_cnt;
	logic [7:0] next_applied;

	// refuse intervals the 9-bit counter cannot hold
	if (INTERVAL < 2 || INTERVAL > 512)
	begin : g_bad_interval
		$error("ramp interval out of range");
	end

	// one move toward the target, never past it
	function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt,
		input logic [7:0] step);
		logic [7:0] r;
		r = tgt;
		if (cur < tgt && (tgt - cur) > step)
		begin
			r = cur + step;
		end
		else if (cur > tgt && (cur - tgt) > step)
		begin
			r = cur - step;
		end
		return r;
	endfunction

	// interval counter and applied code
	always_comb
	begin
		next_tick_cnt = 9'h000;
		next_applied = target; // ramp off: follow the written code at once
		if (ramp_enable)
		begin
			next_applied = applied;
			if (tick_cnt == CNT_LAST)
			begin
				next_applied = step_toward(applied, target,
					fast_rate ? adas_pkg::RAMP_FAST_STEP : adas_pkg::RAMP_SLOW_STEP); // see RQ13
			end
			else
			begin
				next_tick_cnt = tick_cnt + 9'h001;
			end
		end
	end

	// register the ramp state
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt <= 9'h000;
			applied <= adas_pkg::FIELD_RESET;
		end
		else
		begin
			tick_cnt <= next_tick_cnt;
			applied <= next_applied;
		end
	end

	// checks on the ramp pacing
	chk_ramp_hold_between: assert property (@(posedge clk_sys) disable iff (rst) // see RQ13
		ramp_enable && tick_cnt != CNT_LAST |=> applied == $past(applied))
		else $error("coarse moved between ramp ticks");
	chk_ramp_slow_step: assert property (@(posedge clk_sys) disable iff (rst) // see RQ13
		ramp_enable && !fast_rate && tick_cnt == CNT_LAST && applied < target
		|=> applied == 8'($past(applied) + 8'h01))
		else $error("slow ramp did not step by one code");
	chk_ramp_fast_down: assert property (@(posedge clk_sys) disable iff (rst) // see RQ13
		ramp_enable && fast_rate && tick_cnt == CNT_LAST && applied > target
		&& 8'(applied - target) > adas_pkg::RAMP_FAST_STEP
		|=> applied == 8'($past(applied) - adas_pkg::RAMP_FAST_STEP))
		else $error("fast ramp did not step down by four codes");
	cov_ramp_reached: cover property (@(posedge clk_sys) disable iff (rst)
		ramp_enable && $changed(applied) && applied == target);
endmodule

// *** rtl/adas_top.sv ***
// aperture delay adjust registers, calibration status and serial register port
`timescale 1ns/100ps
module adas_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic SCS_N,
	input wire logic SDI,
	output logic SDO,
	input wire logic TIMING_CAL_ENABLE,
	input wire logic TIMING_CAL_FINISHED,
	input wire logic [16:0] TIMING_CAL_WORD,
	input wire logic COARSE_RAMP_ENABLE,
	input wire logic COARSE_RAMP_FAST,
	output logic TIMING_CAL_START,
	output logic SAMPLE_CLOCK_INVERT,
	output logic [7:0] COARSE_DELAY,
	output logic [7:0] FINE_DELAY
);
	logic [2:0] sync_sclk, sync_cs_n, sync_sdi;
	logic [2:0] next_sync_sclk, next_sync_cs_n, next_sync_sdi;
	logic sclk_f, cs_n_f, sdi_f, sclk_q;
	logic next_sclk_f, next_cs_n_f, next_sdi_f;
	adas_pkg::adas_phase_type phase, next_phase;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [23:0] shift_in, next_shift_in;
	logic [7:0] sdo_shift, next_sdo_shift;
	logic next_sdo;
	logic man_invert, next_man_invert;
	logic [7:0] man_coarse, next_man_coarse;
	logic [7:0] man_fine, next_man_fine;
	logic wr_fine;
	logic [7:0] wr_byte;
	logic en_prev, cal_done, next_cal_done;
	logic [16:0] cal_word, next_cal_word;
	logic cal_rise;
	logic [7:0] ramp_coarse;
	logic sclk_rise, sclk_fall;

	// readback of one register byte, unmapped bytes and reserved bits read zero
	function automatic logic [7:0] read_byte(input logic [14:0] addr, input logic [16:0] word,
		input logic done, input logic inv, input logic [7:0] crs, input logic [7:0] fin);
		logic [7:0] r;
		r = 8'h00;
		case (addr)
			adas_pkg::STATUS_OFS: r = word[adas_pkg::FINE_LSB +: 8]; // see RQ3
			adas_pkg::STATUS_OFS + 15'h0001: r = word[adas_pkg::COARSE_LSB +: 8]; // see RQ3
			adas_pkg::STATUS_OFS + 15'h0002: r = {6'h00, done, word[adas_pkg::INV_POS]}; // see RQ2
			adas_pkg::MANUAL_OFS: r = fin;
			adas_pkg::MANUAL_OFS + 15'h0001: r = crs;
			adas_pkg::MANUAL_OFS + 15'h0002: r = {7'h00, inv};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// pin synchronisers: a level counts once stages two and three agree
	always_comb
	begin
		next_sync_sclk = {sync_sclk[1:0], SCLK};
		next_sync_cs_n = {sync_cs_n[1:0], SCS_N};
		next_sync_sdi = {sync_sdi[1:0], SDI};
		next_sclk_f = (sync_sclk[1] == sync_sclk[2]) ? sync_sclk[2] : sclk_f;
		next_cs_n_f = (sync_cs_n[1] == sync_cs_n[2]) ? sync_cs_n[2] : cs_n_f;
		next_sdi_f = (sync_sdi[1] == sync_sdi[2]) ? sync_sdi[2] : sdi_f;
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			sync_sclk <= 3'h0;
			sync_cs_n <= 3'h7;
			sync_sdi <= 3'h0;
			sclk_f <= 1'b0;
			cs_n_f <= 1'b1;
			sdi_f <= 1'b0;
			sclk_q <= 1'b0;
		end
		else
		begin
			sync_sclk <= next_sync_sclk;
			sync_cs_n <= next_sync_cs_n;
			sync_sdi <= next_sync_sdi;
			sclk_f <= next_sclk_f;
			cs_n_f <= next_cs_n_f;
			sdi_f <= next_sdi_f;
			sclk_q <= sclk_f;
		end
	end

	assign sclk_rise = sclk_f & ~sclk_q;
	assign sclk_fall = ~sclk_f & sclk_q;

	// serial frame: shift in on rising sclk, shift out on falling, write at last bit
	always_comb
	begin
		next_phase = phase;
		next_bit_cnt = bit_cnt;
		next_shift_in = shift_in;
		next_sdo_shift = sdo_shift;
		next_sdo = SDO;
		next_man_invert = man_invert;
		next_man_coarse = man_coarse;
		next_man_fine = man_fine;
		wr_fine = 1'b0;
		wr_byte = 8'h00;
		case (phase)
			adas_pkg::PH_IDLE:
			begin
				next_bit_cnt = 5'h00;
				next_sdo = 1'b0;
				if (!cs_n_f)
				begin
					next_phase = adas_pkg::PH_HEAD;
				end
			end
			adas_pkg::PH_HEAD, adas_pkg::PH_DATA:
			begin
				if (sclk_fall && phase == adas_pkg::PH_DATA)
				begin
					next_sdo = sdo_shift[7];
					next_sdo_shift = {sdo_shift[6:0], 1'b0};
				end
				if (sclk_rise)
				begin
					next_shift_in = {shift_in[22:0], sdi_f};
					next_bit_cnt = bit_cnt + 5'h01;
					if (next_bit_cnt == adas_pkg::HEADER_BITS)
					begin
						next_phase = adas_pkg::PH_DATA;
						next_sdo_shift = read_byte(next_shift_in[14:0], cal_word, cal_done,
							man_invert, man_coarse, man_fine);
					end
					if (next_bit_cnt == adas_pkg::FRAME_BITS)
					begin
						next_phase = adas_pkg::PH_WAIT;
						wr_byte = next_shift_in[7:0];
						if (!next_shift_in[23])
						begin
							case (next_shift_in[22:8])
								adas_pkg::MANUAL_OFS:
								begin
									next_man_fine = wr_byte; // see RQ7
									wr_fine = 1'b1;
								end
								adas_pkg::MANUAL_OFS + 15'h0001: next_man_coarse = wr_byte;
								adas_pkg::MANUAL_OFS + 15'h0002: next_man_invert = wr_byte[0];
								default: next_man_fine = man_fine; // status is read only
							endcase
						end
					end
				end
			end
			adas_pkg::PH_WAIT: next_sdo = 1'b0;
			default: next_phase = adas_pkg::PH_IDLE;
		endcase
		if (cs_n_f)
		begin
			next_phase = adas_pkg::PH_IDLE; // deselect aborts any frame
			next_sdo = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			phase <= adas_pkg::PH_IDLE;
			bit_cnt <= 5'h00;
			shift_in <= 24'h000000;
			sdo_shift <= 8'h00;
			SDO <= 1'b0;
			man_invert <= 1'b0;
			man_coarse <= adas_pkg::FIELD_RESET;
			man_fine <= adas_pkg::FIELD_RESET;
		end
		else
		begin
			phase <= next_phase;
			bit_cnt <= next_bit_cnt;
			shift_in <= next_shift_in;
			sdo_shift <= next_sdo_shift;
			SDO <= next_sdo;
			man_invert <= next_man_invert;
			man_coarse <= next_man_coarse;
			man_fine <= next_man_fine;
		end
	end

	// coarse ramp on the manual coarse code
	adas_coarse_ramp #(
		.INTERVAL(adas_pkg::RAMP_INTERVAL_CYC)
	) u_ramp (
		.clk_sys(CLK_SYS),
		.rst(RST),
		.target(man_coarse),
		.ramp_enable(COARSE_RAMP_ENABLE),
		.fast_rate(COARSE_RAMP_FAST),
		.applied(ramp_coarse) // see RQ5
	);

	// calibration start, done flag and captured word
	assign cal_rise = TIMING_CAL_ENABLE & ~en_prev; // see RQ12
	always_comb
	begin
		next_cal_done = TIMING_CAL_ENABLE & (TIMING_CAL_FINISHED | (cal_done & ~cal_rise)); // see RQ1
		next_cal_word = TIMING_CAL_FINISHED && TIMING_CAL_ENABLE ? TIMING_CAL_WORD : cal_word; // see RQ2
	end

	// applied delay: calibrated word while enabled, manual fields otherwise
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			en_prev <= 1'b0;
			cal_done <= adas_pkg::DONE_RESET;
			cal_word <= adas_pkg::WORD_RESET;
			TIMING_CAL_START <= 1'b0;
			SAMPLE_CLOCK_INVERT <= 1'b0;
			COARSE_DELAY <= adas_pkg::FIELD_RESET;
			FINE_DELAY <= adas_pkg::FIELD_RESET;
		end
		else
		begin
			en_prev <= TIMING_CAL_ENABLE;
			cal_done <= next_cal_done; // see RQ14
			cal_word <= next_cal_word;
			TIMING_CAL_START <= cal_rise; // see RQ12
			SAMPLE_CLOCK_INVERT <= TIMING_CAL_ENABLE ? cal_word[adas_pkg::INV_POS] : man_invert; // see RQ4
			COARSE_DELAY <= TIMING_CAL_ENABLE ? cal_word[adas_pkg::COARSE_LSB +: 8] : ramp_coarse; // see RQ5
			FINE_DELAY <= TIMING_CAL_ENABLE ? cal_word[adas_pkg::FINE_LSB +: 8] : man_fine; // see RQ6
		end
	end

	// checks on status and applied delay
	chk_done_on_finish: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ1
		TIMING_CAL_ENABLE && TIMING_CAL_FINISHED |=> cal_done)
		else $error("done flag not set after finish");
	chk_word_capture: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ2
		TIMING_CAL_ENABLE && TIMING_CAL_FINISHED |=> cal_word == $past(TIMING_CAL_WORD))
		else $error("calibrated word not captured");
	chk_cal_fields_applied: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ3
		TIMING_CAL_ENABLE |=> SAMPLE_CLOCK_INVERT == $past(cal_word[16])
		&& COARSE_DELAY == $past(cal_word[15:8]) && FINE_DELAY == $past(cal_word[7:0]))
		else $error("calibrated fields misplaced");
	chk_manual_invert: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ4
		!TIMING_CAL_ENABLE |=> SAMPLE_CLOCK_INVERT == $past(man_invert))
		else $error("manual inversion not applied");
	chk_manual_coarse: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ5
		!TIMING_CAL_ENABLE && !COARSE_RAMP_ENABLE && $past(COARSE_RAMP_ENABLE) == 1'b0
		|=> COARSE_DELAY == $past(man_coarse, 2))
		else $error("manual coarse not applied");
	chk_manual_fine: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ6
		!TIMING_CAL_ENABLE |=> FINE_DELAY == $past(man_fine))
		else $error("manual fine not applied");
	chk_fine_no_defer: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ7
		wr_fine && !TIMING_CAL_ENABLE ##1 !TIMING_CAL_ENABLE |=> FINE_DELAY == $past(wr_byte, 2))
		else $error("fine write deferred");
	chk_start_pulse: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ12
		$rose(TIMING_CAL_ENABLE) |=> TIMING_CAL_START ##1 !TIMING_CAL_START)
		else $error("start pulse wrong");
	chk_done_low_off: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ14
		!TIMING_CAL_ENABLE |=> !cal_done)
		else $error("done set while disabled");
	chk_done_clear_start: assert property (@(posedge CLK_SYS) disable iff (RST) // see RQ14
		$rose(TIMING_CAL_ENABLE) && !TIMING_CAL_FINISHED |=> !cal_done)
		else $error("done not cleared at start");
	cov_cal_done: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(cal_done));
	cov_status_read: cover property (@(posedge CLK_SYS) disable iff (RST)
		phase == adas_pkg::PH_DATA && shift_in[15] && shift_in[14:0] == adas_pkg::STATUS_OFS);
	cov_fine_write: cover property (@(posedge CLK_SYS) disable iff (RST) wr_fine);
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the aperture delay adjust block
`timescale 1ns/100ps
module tb_top;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic SCLK = 1'b0;
	logic SCS_N = 1'b1;
	logic SDI = 1'b0;
	logic SDO;
	logic TIMING_CAL_ENABLE = 1'b0;
	logic TIMING_CAL_FINISHED = 1'b0;
	logic [16:0] TIMING_CAL_WORD = 17'h00000;
	logic COARSE_RAMP_ENABLE = 1'b0;
	logic COARSE_RAMP_FAST = 1'b0;
	logic TIMING_CAL_START;
	logic SAMPLE_CLOCK_INVERT;
	logic [7:0] COARSE_DELAY;
	logic [7:0] FINE_DELAY;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] rd;

	localparam int HALF = 7; // serial half period in system cycles
	localparam int LIMIT = 40000; // run ceiling in system cycles

	adas_top u_adas_top (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.SCLK(SCLK),
		.SCS_N(SCS_N),
		.SDI(SDI),
		.SDO(SDO),
		.TIMING_CAL_ENABLE(TIMING_CAL_ENABLE),
		.TIMING_CAL_FINISHED(TIMING_CAL_FINISHED),
		.TIMING_CAL_WORD(TIMING_CAL_WORD),
		.COARSE_RAMP_ENABLE(COARSE_RAMP_ENABLE),
		.COARSE_RAMP_FAST(COARSE_RAMP_FAST),
		.TIMING_CAL_START(TIMING_CAL_START),
		.SAMPLE_CLOCK_INVERT(SAMPLE_CLOCK_INVERT),
		.COARSE_DELAY(COARSE_DELAY),
		.FINE_DELAY(FINE_DELAY)
	);

	// 25 MHz system clock
	always #20 CLK_SYS = ~CLK_SYS;

	// hang guard
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_errors++;
			summarize();
		end
	end

	// wait n edges, then step off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask

	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one 24-bit serial frame, mode 0, msb first; returns the data phase of SDO
	task automatic frame(input logic rnw, input logic [14:0] addr, input logic [7:0] din,
		output logic [7:0] dout);
		logic [23:0] f;
		f = {rnw, addr, din};
		dout = 8'h00;
		SCS_N = 1'b0;
		cyc(HALF);
		for (int i = 23; i >= 0; i--)
		begin
			SDI = f[i];
			cyc(HALF);
			if (i < 8)
				dout[i] = SDO;
			SCLK = 1'b1;
			cyc(HALF);
			SCLK = 1'b0;
		end
		cyc(HALF);
		SCS_N = 1'b1;
		SDI = 1'b0;
		cyc(8);
	endtask

	task automatic wr(input logic [14:0] addr, input logic [7:0] d);
		logic [7:0] dummy;
		frame(1'b0, addr, d, dummy);
	endtask

	task automatic rdb(input logic [14:0] addr, output logic [7:0] d);
		frame(1'b1, addr, 8'h00, d);
	endtask

	// reset values of the three delay outputs and of both registers
	task automatic t_reset();
		chk("invert", 24'h0, SAMPLE_CLOCK_INVERT);
		chk("coarse", 24'h0, COARSE_DELAY);
		chk("fine", 24'h0, FINE_DELAY);
		for (int k = 0; k < 3; k++)
		begin
			rdb(adas_pkg::MANUAL_OFS + 15'(k), rd);
			chk("manual byte", 24'h0, rd);
			rdb(adas_pkg::STATUS_OFS + 15'(k), rd);
			chk("status byte", 24'h0, rd);
		end
		rdb(15'h0100, rd);
		chk("unmapped read", 24'h0, rd);
	endtask

	// manual fields drive the applied delay while calibration is off
	task automatic t_manual();
		wr(adas_pkg::MANUAL_OFS, 8'hab);
		chk("fine", 24'hab, FINE_DELAY);
		wr(adas_pkg::MANUAL_OFS, 8'h3c);
		chk("fine rewrite", 24'h3c, FINE_DELAY);
		wr(adas_pkg::MANUAL_OFS + 15'h1, 8'h12);
		chk("coarse", 24'h12, COARSE_DELAY);
		wr(adas_pkg::MANUAL_OFS + 15'h2, 8'hff);
		chk("invert", 24'h1, SAMPLE_CLOCK_INVERT);
		rdb(adas_pkg::MANUAL_OFS + 15'h2, rd);
		chk("invert byte", 24'h01, rd);
		wr(adas_pkg::MANUAL_OFS + 15'h2, 8'h00);
		chk("invert clear", 24'h0, SAMPLE_CLOCK_INVERT);
		rdb(adas_pkg::MANUAL_OFS + 15'h1, rd);
		chk("coarse byte", 24'h12, rd);
	endtask

	// calibration start, done flag, captured word and manual override
	task automatic t_cal();
		TIMING_CAL_ENABLE = 1'b1;
		chk("start early", 24'h0, TIMING_CAL_START);
		cyc(1);
		chk("start pulse", 24'h1, TIMING_CAL_START);
		cyc(1);
		chk("start end", 24'h0, TIMING_CAL_START);
		rdb(adas_pkg::STATUS_OFS + 15'h2, rd);
		chk("done before finish", 24'h0, rd);
		TIMING_CAL_WORD = 17'h15ac3;
		TIMING_CAL_FINISHED = 1'b1;
		cyc(1);
		TIMING_CAL_FINISHED = 1'b0;
		TIMING_CAL_WORD = 17'h00000;
		cyc(2);
		chk("cal invert", 24'h1, SAMPLE_CLOCK_INVERT);
		chk("cal coarse", 24'h5a, COARSE_DELAY);
		chk("cal fine", 24'hc3, FINE_DELAY);
		rdb(adas_pkg::STATUS_OFS, rd);
		chk("status low", 24'hc3, rd);
		rdb(adas_pkg::STATUS_OFS + 15'h1, rd);
		chk("status mid", 24'h5a, rd);
		rdb(adas_pkg::STATUS_OFS + 15'h2, rd);
		chk("status top", 24'h03, rd);
		wr(adas_pkg::STATUS_OFS, 8'hff);
		rdb(adas_pkg::STATUS_OFS, rd);
		chk("status read only", 24'hc3, rd);
		wr(adas_pkg::MANUAL_OFS, 8'h11);
		chk("manual ignored", 24'hc3, FINE_DELAY);
		// disable clears the done flag; it stays 0 after a second start
		TIMING_CAL_ENABLE = 1'b0;
		cyc(2);
		TIMING_CAL_ENABLE = 1'b1;
		cyc(3);
		rdb(adas_pkg::STATUS_OFS + 15'h2, rd);
		chk("done after restart", 24'h00, rd[1]);
		TIMING_CAL_ENABLE = 1'b0;
		cyc(3);
		chk("fine back", 24'h11, FINE_DELAY);
		chk("invert back", 24'h0, SAMPLE_CLOCK_INVERT);
		chk("coarse back", 24'h12, COARSE_DELAY);
		TIMING_CAL_FINISHED = 1'b1;
		cyc(1);
		TIMING_CAL_FINISHED = 1'b0;
		rdb(adas_pkg::STATUS_OFS + 15'h2, rd);
		// finish is ignored while off: done stays 0, the old word's inversion bit remains
		chk("done while off", 24'h01, rd);
	endtask

	// slow ramp: one code per interval toward the written target
	task automatic t_ramp();
		int w;
		COARSE_RAMP_ENABLE = 1'b1;
		cyc(2);
		wr(adas_pkg::MANUAL_OFS + 15'h1, 8'h14);
		w = 0;
		while (COARSE_DELAY === 8'h12 && w < 400)
		begin
			cyc(1);
			w++;
		end
		chk("ramp first", 24'h13, COARSE_DELAY);
		cyc(adas_pkg::RAMP_INTERVAL_CYC - 8);
		chk("ramp hold", 24'h13, COARSE_DELAY);
		cyc(10);
		chk("ramp second", 24'h14, COARSE_DELAY);
		cyc(adas_pkg::RAMP_INTERVAL_CYC + 4);
		chk("ramp stop", 24'h14, COARSE_DELAY);
		COARSE_RAMP_ENABLE = 1'b0;
		wr(adas_pkg::MANUAL_OFS + 15'h1, 8'h40);
		chk("jump", 24'h40, COARSE_DELAY);
		wr(adas_pkg::MANUAL_OFS + 15'h1, 8'h41);
		chk("coarse step", 24'h41, COARSE_DELAY);
		// fast ramp downward: four codes per interval, no overshoot at the end
		COARSE_RAMP_FAST = 1'b1;
		COARSE_RAMP_ENABLE = 1'b1;
		wr(adas_pkg::MANUAL_OFS + 15'h1, 8'h37);
		w = 0;
		while (COARSE_DELAY === 8'h41 && w < 400)
		begin
			cyc(1);
			w++;
		end
		chk("fast first", 24'h3d, COARSE_DELAY);
		cyc(adas_pkg::RAMP_INTERVAL_CYC + 2);
		chk("fast second", 24'h39, COARSE_DELAY);
		cyc(adas_pkg::RAMP_INTERVAL_CYC);
		chk("fast last", 24'h37, COARSE_DELAY);
		COARSE_RAMP_ENABLE = 1'b0;
		COARSE_RAMP_FAST = 1'b0;
	endtask

	// main sequence
	initial
	begin
		cyc(10);
		RST = 1'b0;
		cyc(2);
		t_reset();
		t_manual();
		t_cal();
		t_ramp();
		summarize();
	end
endmodule
